// ===== logic/cvlp_apb_slave.sv
`include "cvlp_cfg.svh"

module cvlp_apb_slave
    import cvlp_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic             pslverr,
    // Decoded access
    output logic             wr_en,
    output logic [7:0]       reg_idx,
    output logic [15:0]      wr_data,
    output logic [1:0]       wr_lanes,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_hit,
    output logic [31:0]      prdata
);

    logic [31:0] prdata_ff;
    logic        access;

    // Zero wait states: every access completes in its first access cycle
    assign access   = psel & penable;
    assign pready   = 1'b1;
    assign reg_idx  = paddr[9:2];
    assign wr_data  = pwdata[15:0];
    assign wr_lanes = pstrb[1:0];
    assign wr_en    = access & pwrite & rd_hit & (paddr[1:0] == 2'h0);
    assign pslverr  = access & (~rd_hit | (paddr[1:0] != 2'h0));

    // Read data held in a register, launched in the setup cycle
    // Misaligned reads are refused, so they must not leak register data
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata_ff <= 32'h0;
        end else if (psel & ~penable & ~pwrite) begin
            prdata_ff <= {16'h0,
                          (paddr[1:0] == 2'h0) ? rd_data : 16'h0};
        end
    end

    assign prdata = prdata_ff;

endmodule

// ===== logic/cvlp_cfg.svh
`ifndef CVLP_CFG_SVH
`define CVLP_CFG_SVH

// Register indices as printed; byte address is four times the index
`define CVLP_IDX_CONV1_LP       8'hB6
`define CVLP_IDX_CONV2_CTRL     8'hB7
`define CVLP_IDX_CONV1_VSEL     8'hB4
`define CVLP_IDX_SLEEP_CTRL     8'hC0
`define CVLP_IDX_STATUS         8'hC1

// Converter-1 low power fields
`define CVLP_C1_BEH_MSB         14
`define CVLP_C1_BEH_LSB         12
`define CVLP_C1_SRC_MSB         9
`define CVLP_C1_SRC_LSB         8
`define CVLP_C1_ALT_MSB         6
`define CVLP_C1_ALT_LSB         0
`define CVLP_C1_LP_RST          16'h1006
`define CVLP_C1_LP_MASK         16'h737F

// Converter-1 normal voltage code
`define CVLP_C1_VSEL_RST        7'h0E

// Converter-2 control fields
`define CVLP_C2_TOPO_BIT        14
`define CVLP_C2_BEH_BIT         12
`define CVLP_C2_SRC_MSB         9
`define CVLP_C2_SRC_LSB         8
`define CVLP_C2_ILIM_BIT        6
`define CVLP_C2_RMPH_BIT        4
`define CVLP_C2_RMPL_BIT        3
`define CVLP_C2_FB_MSB          1
`define CVLP_C2_FB_LSB          0
`define CVLP_C2_CTRL_RST        16'h0018
`define CVLP_C2_CTRL_MASK       16'h535B

// Voltage code limit, lowest ramp range code and USB divider feedback code
`define CVLP_VCODE_MAX          7'h66
`define CVLP_RAMP_LOWEST        2'h3
`define CVLP_FB_USB_DIV         2'h3

`endif

// ===== logic/cvlp_pkg.sv
package cvlp_pkg;

    typedef enum logic [2:0] {
        CVLP_C1_KEEP        = 3'h0,
        CVLP_C1_ALT         = 3'h1,
        CVLP_C1_STBY        = 3'h2,
        CVLP_C1_STBY_ALT    = 3'h3,
        CVLP_C1_LINREG      = 3'h4,
        CVLP_C1_LINREG_ALT  = 3'h5,
        CVLP_C1_RSVD        = 3'h6,
        CVLP_C1_OFF         = 3'h7
    } cvlp_c1_beh_t;

    typedef enum logic [1:0] {
        CVLP_MODE_NORMAL  = 2'h0,
        CVLP_MODE_STANDBY = 2'h1,
        CVLP_MODE_LINREG  = 2'h2
    } cvlp_op_mode_t;

    typedef enum logic [1:0] {
        CVLP_SRC_REG  = 2'h0,
        CVLP_SRC_PIN1 = 2'h1,
        CVLP_SRC_PIN2 = 2'h2,
        CVLP_SRC_PIN3 = 2'h3
    } cvlp_src_t;

    typedef enum logic [1:0] {
        CVLP_FB_EXT_DIV = 2'h0,
        CVLP_FB_SINK_A  = 2'h1,
        CVLP_FB_SINK_B  = 2'h2,
        CVLP_FB_USB     = 2'h3
    } cvlp_fb_t;

endpackage

// ===== logic/cvlp_sleep_sel.sv
`include "cvlp_cfg.svh"

module cvlp_sleep_sel
    import cvlp_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       psm_reset,
    // Request sources
    input  wire logic [1:0] source_sel,
    input  wire logic       sleep_reg_bit,
    input  wire logic [2:0] low_power_pins,
    input  wire logic       gpio_sleep_in,
    // Result
    output logic            sleep_active
);

    logic nxt_sleep;
    logic sleep_ff;

    always_comb begin
        case (cvlp_src_t'(source_sel))
            CVLP_SRC_REG:  nxt_sleep = sleep_reg_bit;
            CVLP_SRC_PIN1: nxt_sleep = low_power_pins[0];
            CVLP_SRC_PIN2: nxt_sleep = low_power_pins[1];
            default:       nxt_sleep = low_power_pins[2];
        endcase
        nxt_sleep = nxt_sleep | gpio_sleep_in;
    end

    // Registered so the converter controls never glitch on pin edges
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sleep_ff <= 1'b0;
        end else if (psm_reset) begin
            sleep_ff <= 1'b0;
        end else begin
            sleep_ff <= nxt_sleep;
        end
    end

    assign sleep_active = sleep_ff;

endmodule

// ===== logic/cvlp_top.sv
`include "cvlp_cfg.svh"

// Notes on behaviour
// RULE1: Sleep code 000 keeps settings and 001 uses the image voltage code.
// RULE2: Sleep code 010 forces standby and 011 forces standby plus image code.
// RULE3: Sleep code 100 forces linear mode and 101 adds the image code.
// RULE4: Sleep code 111 disables converter 1 output; 110 is reserved.
// RULE5: Converter-1 source 00 is the register bit, 01-11 the three pins.
// RULE6: A GPIO sleep input also requests sleep for both converters.
// RULE7: Image code is 7 bits of 25 mV steps from 0.85 V, max 0x66.
// RULE8: Otherwise converter 1 uses its normal 7-bit voltage code.
// RULE9: Converter-2 topology bit 14 is boost at 0, switch at 1, reset 0.
// RULE10: Converter-2 sleep bit 12 keeps running at 0, disables at 1.
// RULE11: Converter-2 source select uses the converter-1 encoding.
// RULE12: Converter-2 bit 6 picks higher peak current at 0, lower at 1.
// RULE13: Ramp bits 4 and 3 form a range code that resets to 11.
// RULE14: Feedback source 11 forces the lowest-voltage ramp range.
// RULE15: Feedback 00 external, 01 sink A, 10 sink B, 11 USB divider.
// RULE16: All fields return to defaults on the power state machine reset.
// RULE17: When sleep ends, each converter returns to its active settings.
module cvlp_top
    import cvlp_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        psm_reset,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Sleep request inputs
    input  wire logic        low_power_pin_one,
    input  wire logic        low_power_pin_two,
    input  wire logic        low_power_pin_three,
    input  wire logic        gpio_sleep_in,
    // Converter 1 controls
    output logic [6:0]       conv1_vcode,
    output logic [1:0]       conv1_op_mode,
    output logic             conv1_enable,
    // Converter 2 controls
    output logic             conv2_topology_sel,
    output logic             conv2_enable,
    output logic             conv2_peak_current_sel,
    output logic [1:0]       conv2_ramp_range,
    output logic [1:0]       conv2_feedback_source
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus

    logic        wr_en;
    logic [7:0]  reg_idx;
    logic [15:0] wr_data;
    logic [1:0]  wr_lanes;
    logic [15:0] rd_data;
    logic        rd_hit;

    logic [15:0] conv1_lp_ff;
    logic [15:0] conv2_ctrl_ff;
    logic [6:0]  conv1_voltage_code_ff;
    logic        sleep_reg_bit_ff;
    logic        conv1_sleep_ff;
    logic        conv2_sleep_ff;

    cvlp_apb_slave u_apb (
        .clock    (clock),
        .rstn     (rstn),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .pstrb    (pstrb),
        .pready   (pready),
        .pslverr  (pslverr),
        .wr_en    (wr_en),
        .reg_idx  (reg_idx),
        .wr_data  (wr_data),
        .wr_lanes (wr_lanes),
        .rd_data  (rd_data),
        .rd_hit   (rd_hit),
        .prdata   (prdata)
    );

    // Byte-lane merge, used for the conv1_lp_ff and conv2_ctrl_ff registers
    function automatic logic [15:0] merge16(
        input logic [15:0] old_val,
        input logic [15:0] new_val,
        input logic [1:0]  lanes,
        input logic [15:0] mask
    );
        logic [15:0] res;
        res = old_val;
        if (lanes[0]) begin
            res[7:0] = new_val[7:0];
        end
        if (lanes[1]) begin
            res[15:8] = new_val[15:8];
        end
        merge16 = res & mask;
    endfunction

    function automatic logic is_idx(
        input logic [7:0] idx,
        input logic [7:0] want
    );
        is_idx = (idx == want);
    endfunction

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 16'h0;
        if (is_idx(reg_idx, `CVLP_IDX_CONV1_LP)) begin
            rd_data = conv1_lp_ff;
        end else if (is_idx(reg_idx, `CVLP_IDX_CONV2_CTRL)) begin
            rd_data = conv2_ctrl_ff;
        end else if (is_idx(reg_idx, `CVLP_IDX_CONV1_VSEL)) begin
            rd_data = {9'h0, conv1_voltage_code_ff};
        end else if (is_idx(reg_idx, `CVLP_IDX_SLEEP_CTRL)) begin
            rd_data = {15'h0, sleep_reg_bit_ff};
        end else if (is_idx(reg_idx, `CVLP_IDX_STATUS)) begin
            rd_data = {14'h0, conv2_sleep_ff, conv1_sleep_ff};
        end else begin
            rd_hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conv1_lp_ff <= `CVLP_C1_LP_RST;
        end else if (psm_reset) begin
            conv1_lp_ff <= `CVLP_C1_LP_RST;  // RULE16
        end else if (wr_en && is_idx(reg_idx, `CVLP_IDX_CONV1_LP)) begin
            conv1_lp_ff <= merge16(conv1_lp_ff, wr_data, wr_lanes,
                                   `CVLP_C1_LP_MASK);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conv2_ctrl_ff <= `CVLP_C2_CTRL_RST;
        end else if (psm_reset) begin
            conv2_ctrl_ff <= `CVLP_C2_CTRL_RST;  // RULE16 RULE9 RULE13
        end else if (wr_en && is_idx(reg_idx, `CVLP_IDX_CONV2_CTRL)) begin
            conv2_ctrl_ff <= merge16(conv2_ctrl_ff, wr_data, wr_lanes,
                                     `CVLP_C2_CTRL_MASK);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conv1_voltage_code_ff <= `CVLP_C1_VSEL_RST;
        end else if (psm_reset) begin
            conv1_voltage_code_ff <= `CVLP_C1_VSEL_RST;
        end else if (wr_en && wr_lanes[0]
                     && is_idx(reg_idx, `CVLP_IDX_CONV1_VSEL)) begin
            conv1_voltage_code_ff <= wr_data[6:0];  // RULE8
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sleep_reg_bit_ff <= 1'b0;
        end else if (psm_reset) begin
            sleep_reg_bit_ff <= 1'b0;
        end else if (wr_en && wr_lanes[0]
                     && is_idx(reg_idx, `CVLP_IDX_SLEEP_CTRL)) begin
            sleep_reg_bit_ff <= wr_data[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep request selection

    logic [2:0] lp_pins;
    assign lp_pins = {low_power_pin_three, low_power_pin_two,
                      low_power_pin_one};

    cvlp_sleep_sel u_sel1 (
        .clock          (clock),
        .rstn           (rstn),
        .psm_reset      (psm_reset),
        .source_sel     (conv1_lp_ff[`CVLP_C1_SRC_MSB:`CVLP_C1_SRC_LSB]),
        .sleep_reg_bit  (sleep_reg_bit_ff),
        .low_power_pins (lp_pins),
        .gpio_sleep_in  (gpio_sleep_in),
        .sleep_active   (conv1_sleep_ff)
    );  // RULE5 RULE6

    cvlp_sleep_sel u_sel2 (
        .clock          (clock),
        .rstn           (rstn),
        .psm_reset      (psm_reset),
        .source_sel     (conv2_ctrl_ff[`CVLP_C2_SRC_MSB:`CVLP_C2_SRC_LSB]),
        .sleep_reg_bit  (sleep_reg_bit_ff),
        .low_power_pins (lp_pins),
        .gpio_sleep_in  (gpio_sleep_in),
        .sleep_active   (conv2_sleep_ff)
    );  // RULE11 RULE6

    ////////////////////////////////////////////////////////////////////////
    // Converter 1 outputs

    cvlp_c1_beh_t  c1_beh;
    logic [6:0]    nxt_c1_vcode;
    logic [1:0]    nxt_c1_mode;
    logic          nxt_c1_en;
    logic [6:0]    c1_vcode_ff;
    logic [1:0]    c1_mode_ff;
    logic          c1_en_ff;

    assign c1_beh = cvlp_c1_beh_t'(
        conv1_lp_ff[`CVLP_C1_BEH_MSB:`CVLP_C1_BEH_LSB]);

    always_comb begin
        nxt_c1_vcode = conv1_voltage_code_ff;  // RULE8 RULE17
        nxt_c1_mode  = CVLP_MODE_NORMAL;
        nxt_c1_en    = 1'b1;
        if (conv1_sleep_ff) begin
            case (c1_beh)
                CVLP_C1_KEEP: begin
                    nxt_c1_vcode = conv1_voltage_code_ff;  // RULE1
                end
                CVLP_C1_ALT: begin
                    nxt_c1_vcode = conv1_lp_ff[6:0];  // RULE1 RULE7
                end
                CVLP_C1_STBY: begin
                    nxt_c1_mode = CVLP_MODE_STANDBY;  // RULE2
                end
                CVLP_C1_STBY_ALT: begin
                    nxt_c1_mode  = CVLP_MODE_STANDBY;  // RULE2
                    nxt_c1_vcode = conv1_lp_ff[6:0];
                end
                CVLP_C1_LINREG: begin
                    nxt_c1_mode = CVLP_MODE_LINREG;  // RULE3
                end
                CVLP_C1_LINREG_ALT: begin
                    nxt_c1_mode  = CVLP_MODE_LINREG;  // RULE3
                    nxt_c1_vcode = conv1_lp_ff[6:0];
                end
                CVLP_C1_OFF: begin
                    nxt_c1_en = 1'b0;  // RULE4
                end
                default: begin
                    // Reserved code behaves as no change
                    nxt_c1_vcode = conv1_voltage_code_ff;  // RULE4
                end
            endcase
        end
        // Codes above the top step are clamped to the usable maximum
        if (nxt_c1_vcode > `CVLP_VCODE_MAX) begin
            nxt_c1_vcode = `CVLP_VCODE_MAX;  // RULE7
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            c1_vcode_ff <= `CVLP_C1_VSEL_RST;
            c1_mode_ff  <= CVLP_MODE_NORMAL;
            c1_en_ff    <= 1'b1;
        end else begin
            c1_vcode_ff <= nxt_c1_vcode;
            c1_mode_ff  <= nxt_c1_mode;
            c1_en_ff    <= nxt_c1_en;
        end
    end

    assign conv1_vcode   = c1_vcode_ff;
    assign conv1_op_mode = c1_mode_ff;
    assign conv1_enable  = c1_en_ff;

    ////////////////////////////////////////////////////////////////////////
    // Converter 2 outputs

    logic [1:0] nxt_c2_ramp;
    logic       nxt_c2_en;
    logic       c2_topo_ff;
    logic       c2_en_ff;
    logic       c2_ilim_ff;
    logic [1:0] c2_ramp_ff;
    logic [1:0] c2_fb_ff;

    always_comb begin
        nxt_c2_ramp = {conv2_ctrl_ff[`CVLP_C2_RMPH_BIT],
                       conv2_ctrl_ff[`CVLP_C2_RMPL_BIT]};  // RULE13
        if (conv2_ctrl_ff[`CVLP_C2_FB_MSB:`CVLP_C2_FB_LSB]
            == `CVLP_FB_USB_DIV) begin
            nxt_c2_ramp = `CVLP_RAMP_LOWEST;  // RULE14
        end
        // Running resumes as soon as the request drops
        nxt_c2_en = ~(conv2_sleep_ff
                      & conv2_ctrl_ff[`CVLP_C2_BEH_BIT]);  // RULE10 RULE17
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            c2_topo_ff <= 1'b0;
            c2_en_ff   <= 1'b1;
            c2_ilim_ff <= 1'b0;
            c2_ramp_ff <= `CVLP_RAMP_LOWEST;
            c2_fb_ff   <= CVLP_FB_EXT_DIV;
        end else begin
            c2_topo_ff <= conv2_ctrl_ff[`CVLP_C2_TOPO_BIT];  // RULE9
            c2_en_ff   <= nxt_c2_en;
            c2_ilim_ff <= conv2_ctrl_ff[`CVLP_C2_ILIM_BIT];  // RULE12
            c2_ramp_ff <= nxt_c2_ramp;
            c2_fb_ff   <= conv2_ctrl_ff[`CVLP_C2_FB_MSB:
                                        `CVLP_C2_FB_LSB];  // RULE15
        end
    end

    assign conv2_topology_sel     = c2_topo_ff;
    assign conv2_enable           = c2_en_ff;
    assign conv2_peak_current_sel = c2_ilim_ff;
    assign conv2_ramp_range       = c2_ramp_ff;
    assign conv2_feedback_source  = c2_fb_ff;

endmodule

// ===== tb/cvlp_assertions.sv
module cvlp_chk (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        psm_reset,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Converter controls
    input wire logic [6:0]  conv1_vcode,
    input wire logic [1:0]  conv1_op_mode,
    input wire logic        conv2_topology_sel,
    input wire logic        conv2_peak_current_sel,
    input wire logic [1:0]  conv2_ramp_range,
    input wire logic [1:0]  conv2_feedback_source
);
    logic bad;
    logic wr_hit;

    // Only address bits 9:2 decode, so upper bits alias
    assign bad = (paddr[1:0] != 2'h0) ||
                 !(paddr[9:2] inside {8'hB4, 8'hB6, 8'hB7, 8'hC0, 8'hC1});
    assign wr_hit = psel & penable & pwrite;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_pready_zero: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_err_decode: assert property (psel && penable |-> pslverr == bad)
        else $error("pslverr does not match address decode");
    a_err_quiet: assert property (!(psel && penable) |-> !pslverr)
        else $error("pslverr outside access phase");
    a_err_nodata: assert property (psel && penable && !pwrite && bad
        |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_upper_zero: assert property (psel && penable && !pwrite
        |-> prdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    a_vcode_max: assert property (conv1_vcode <= 7'h66)
        else $error("conv1 voltage code above maximum");
    a_mode_legal: assert property (conv1_op_mode != 2'h3)
        else $error("conv1 mode code illegal");
    a_ramp_forced: assert property (conv2_feedback_source == 2'h3
        |-> conv2_ramp_range == 2'h3)
        else $error("ramp not forced for internal divider");
    a_psm_default: assert property (psm_reset |-> ##2
        (!conv2_topology_sel && !conv2_peak_current_sel &&
         conv2_feedback_source == 2'h0 && conv2_ramp_range == 2'h3))
        else $error("conv2 outputs not default after state reset");
    a_topo_cause: assert property ($changed(conv2_topology_sel)
        |-> $past(wr_hit, 2) || $past(psm_reset, 2))
        else $error("topology changed without a write");
endmodule

bind cvlp_top cvlp_chk u_chk (
    .clock(clock), .rstn(rstn), .psm_reset(psm_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .conv1_vcode(conv1_vcode),
    .conv1_op_mode(conv1_op_mode), .conv2_topology_sel(conv2_topology_sel),
    .conv2_peak_current_sel(conv2_peak_current_sel),
    .conv2_ramp_range(conv2_ramp_range),
    .conv2_feedback_source(conv2_feedback_source)
);

// ===== tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] A_LP = 12'h2D8;
    localparam logic [11:0] A_C2 = 12'h2DC;
    localparam logic [11:0] A_VS = 12'h2D0;
    localparam logic [11:0] A_SL = 12'h300;

    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        psm_reset = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [2:0]  pins = 3'h0;
    logic        gpio_sleep_in = 1'b0;
    logic        pready, pslverr, conv1_enable, conv2_topology_sel;
    logic        conv2_enable, conv2_peak_current_sel, er;
    logic [31:0] prdata, rd;
    logic [6:0]  conv1_vcode;
    logic [1:0]  conv1_op_mode, conv2_ramp_range, conv2_feedback_source;
    int          miscompares = 0;
    int          checks = 0;
    int          cyc = 0;

    always #25 clock = ~clock;

    cvlp_top DUT (
        .clock(clock), .rstn(rstn), .psm_reset(psm_reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .low_power_pin_one(pins[0]), .low_power_pin_two(pins[1]),
        .low_power_pin_three(pins[2]), .gpio_sleep_in(gpio_sleep_in),
        .conv1_vcode(conv1_vcode), .conv1_op_mode(conv1_op_mode),
        .conv1_enable(conv1_enable), .conv2_topology_sel(conv2_topology_sel),
        .conv2_enable(conv2_enable),
        .conv2_peak_current_sel(conv2_peak_current_sel),
        .conv2_ramp_range(conv2_ramp_range),
        .conv2_feedback_source(conv2_feedback_source)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Request held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // Only the bench timeout ends a wait that never answers
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check("read data", rd, exp);
    endtask

    // Outputs trail a write or pin change by two edges; margin added
    task automatic settle();
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic c1(input logic [6:0] v, input logic [1:0] m);
        check("conv1_vcode", {25'h0, conv1_vcode}, {25'h0, v});
        check("conv1_op_mode", {30'h0, conv1_op_mode}, {30'h0, m});
    endtask

    task automatic c2(input logic [1:0] r, input logic [1:0] f);
        check("conv2_ramp_range", {30'h0, conv2_ramp_range}, {30'h0, r});
        check("conv2_fb", {30'h0, conv2_feedback_source}, {30'h0, f});
    endtask

    task automatic en(input logic e1, input logic e2);
        check("conv1_enable", {31'h0, conv1_enable}, {31'h0, e1});
        check("conv2_enable", {31'h0, conv2_enable}, {31'h0, e2});
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [2:0] msk;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        c1(7'h0E, 2'h0);
        c2(2'h3, 2'h0);
        check("conv2_topology", {31'h0, conv2_topology_sel}, 32'h0);
        rdc(A_LP, 32'h1006);
        rdc(A_C2, 32'h0018);
        xfer(1'b0, 12'h3FC, 32'h0);
        check("unmapped error", {31'h0, er}, 32'h1);
        check("unmapped data", rd, 32'h0);
        xfer(1'b1, 12'h2DA, 32'h0);
        check("misaligned write error", {31'h0, er}, 32'h1);
        xfer(1'b0, 12'h2D9, 32'h0);
        check("misaligned read error", {31'h0, er}, 32'h1);
        check("misaligned read data", rd, 32'h0);
        rdc(A_LP, 32'h1006);
        // Every sleep behaviour code, sleep requested by register bit
        wr(A_VS, 32'h10);
        wr(A_SL, 32'h1);
        for (int c = 0; c < 8; c++) begin
            wr(A_LP, {17'h0, c[2:0], 5'h0, 7'h20});
            settle();
            en(c != 7, 1'b1);
            if (c != 7) begin
                c1((c == 1 || c == 3 || c == 5) ? 7'h20 : 7'h10,
                   (c == 2 || c == 3) ? 2'h1 :
                   (c == 4 || c == 5) ? 2'h2 : 2'h0);
            end
        end
        wr(A_SL, 32'h0);
        settle();
        c1(7'h10, 2'h0);
        en(1'b1, 1'b1);
        // Source select: unselected pins must not trigger sleep
        for (int s = 0; s < 4; s++) begin
            msk = (s == 0) ? 3'h0 : 3'h1 << (s - 1);
            wr(A_LP, {17'h0, 3'h1, 2'h0, s[1:0], 1'h0, 7'h20});
            @(posedge clock);
            pins <= ~msk;
            settle();
            c1(7'h10, 2'h0);
            @(posedge clock);
            pins <= msk;
            settle();
            c1((s != 0) ? 7'h20 : 7'h10, 2'h0);
            @(posedge clock);
            pins <= 3'h0;
        end
        wr(A_SL, 32'h1);
        wr(A_LP, 32'h1066);
        settle();
        c1(7'h66, 2'h0);
        wr(A_SL, 32'h0);
        // Converter 2 fields, source pin one
        wr(A_C2, 32'h5149);
        settle();
        check("conv2_topology", {31'h0, conv2_topology_sel}, 32'h1);
        check("conv2_peak", {31'h0, conv2_peak_current_sel}, 32'h1);
        c2(2'h1, 2'h1);
        rdc(A_C2, 32'h5149);
        @(posedge clock);
        pins <= 3'h1;
        settle();
        en(1'b1, 1'b0);
        @(posedge clock);
        pins <= 3'h0;
        gpio_sleep_in <= 1'b1;
        settle();
        en(1'b1, 1'b0);
        c1(7'h66, 2'h0);
        rdc(12'h304, 32'h3);
        @(posedge clock);
        gpio_sleep_in <= 1'b0;
        settle();
        en(1'b1, 1'b1);
        c1(7'h10, 2'h0);
        // Feedback sources with ramp code 10
        for (int f = 0; f < 4; f++) begin
            wr(A_C2, {30'h4, f[1:0]});
            settle();
            c2((f == 3) ? 2'h3 : 2'h2, f[1:0]);
        end
        rdc(A_C2, 32'h0013);
        @(posedge clock);
        psm_reset <= 1'b1;
        @(posedge clock);
        psm_reset <= 1'b0;
        settle();
        rdc(A_LP, 32'h1006);
        rdc(A_C2, 32'h0018);
        @(negedge clock);
        c1(7'h0E, 2'h0);
        c2(2'h3, 2'h0);
        end_sim();
    end
endmodule
